// ==== src/fdh_defs.vh ====
// constants of the fixed disk host port: ports, fields, codes and sizes
`ifndef FDH_DEFS_VH
`define FDH_DEFS_VH

// ==========================================
// i/o port addresses (10-bit i/o space)
`define FDH_DATA_PORT    10'h320
`define FDH_COND_PORT    10'h321
`define FDH_SEL_PORT     10'h322
`define FDH_MASK_PORT    10'h323

// ==========================================
// command block and sense sizes
`define FDH_BLK_BYTES    3'h6
`define FDH_SENSE_BYTES  3'h4
`define FDH_BLK_LAST     3'h5
`define FDH_SENSE_LAST   3'h3

// ==========================================
// completion status byte fields
`define FDH_STAT_ERR_BIT 1
`define FDH_STAT_DRV_BIT 5

// ==========================================
// controller_condition bits
`define FDH_COND_REQ     0
`define FDH_COND_TOHOST  1
`define FDH_COND_CMDPH   2
`define FDH_COND_BUSY    3
`define FDH_COND_IRQ     5

// ==========================================
// mask register bits and reset value
`define FDH_MASK_IRQ_EN  0
`define FDH_MASK_DMA_EN  1
`define FDH_MASK_RESET   2'h0

// ==========================================
// command opcode that returns sense bytes, and the ecc data-error code
`define FDH_OPC_SENSE    5'h03
`define FDH_ERR_DATA     6'h11

// ==========================================
// ecc generator
`define FDH_ECC_POLY     32'h04c11db7
`define FDH_ECC_SEED     32'h00000000

`endif

// ==== src/fdh_ecc32.v ====
// 32-bit ecc syndrome generator over the record byte stream
`include "fdh_defs.vh"

module fdh_ecc32 #(
    parameter [31:0] POLY = `FDH_ECC_POLY
) (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_sys_rst,
    // byte stream
    input  wire        i_clear,
    input  wire        i_byte_valid,
    input  wire [7:0]  i_byte,
    // result
    output wire [31:0] o_syndrome,
    output wire        o_nonzero
);

    reg [31:0] syn_ff;   // running remainder

    // ==========================================
    // one byte step of the division, msb first
    function [31:0] ecc_step;
        input [31:0] rem;
        input [7:0]  dat;
        integer      k;
        reg   [31:0] r;
        begin
            r = rem;
            for (k = 7; k >= 0; k = k - 1) begin
                if (r[31] ^ dat[k]) begin
                    r = {r[30:0], 1'b0} ^ POLY;
                end else begin
                    r = {r[30:0], 1'b0};
                end
            end
            ecc_step = r;
        end
    endfunction

    // remainder register: cleared per command, stepped per byte
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            syn_ff <= `FDH_ECC_SEED;
        end else if (i_clear) begin
            syn_ff <= `FDH_ECC_SEED;
        end else if (i_byte_valid) begin
            syn_ff <= ecc_step(syn_ff, i_byte);
        end
    end

    assign o_syndrome = syn_ff;
    assign o_nonzero  = |syn_ff;

endmodule

// ==== src/fdh_host_port.v ====
// fixed disk controller host port: i/o registers, command stack, dma and completion
`include "fdh_defs.vh"

module fdh_host_port #(
    parameter ADDR_W = 10
) (
    // clock and reset
    input  wire              i_sys_clk,
    input  wire              i_sys_rst,
    // i/o bus pins
    input  wire [ADDR_W-1:0] i_io_addr,
    input  wire [7:0]        i_io_data,
    input  wire              i_io_aen,
    input  wire              i_io_rd_n,
    input  wire              i_io_wr_n,
    output reg  [7:0]        o_io_data,
    output reg               o_io_data_oe_n,
    // dma and interrupt pins
    input  wire              i_dma_ack_n,
    input  wire              i_dma_tc,
    output reg               o_dma_req,
    output reg               o_irq,
    // controller select pulse
    output reg               o_sel_pulse,
    // command to the execution engine
    output reg               o_cmd_start,
    output reg  [7:0]        o_cmd_class_op,
    output reg               o_cmd_drive,
    output reg  [4:0]        o_cmd_head,
    output reg  [9:0]        o_cmd_cyl,
    output reg  [5:0]        o_cmd_sector,
    output reg  [7:0]        o_cmd_count,
    output reg  [7:0]        o_cmd_control,
    // record bytes, disk to memory
    input  wire              i_rd_valid,
    input  wire [7:0]        i_rd_byte,
    output wire              o_rd_ready,
    // record bytes, memory to disk
    input  wire              i_wr_want,
    output reg               o_wr_valid,
    output reg  [7:0]        o_wr_byte,
    output reg               o_dma_tc_seen,
    // completion from the execution engine
    input  wire              i_exec_done,
    input  wire [1:0]        i_exec_err_type,
    input  wire [3:0]        i_exec_err_code,
    input  wire              i_exec_addr_valid,
    input  wire              i_exec_chk_ecc,
    output wire [31:0]       o_ecc_syndrome
);

    // ==========================================
    // states, one-hot
    localparam [4:0] ST_IDLE  = 5'h01;  // no command, not busy
    localparam [4:0] ST_CMD   = 5'h02;  // collecting command block
    localparam [4:0] ST_EXEC  = 5'h04;  // engine running, dma active
    localparam [4:0] ST_SENSE = 5'h08;  // presenting sense bytes
    localparam [4:0] ST_STAT  = 5'h10;  // completion status waiting
    localparam       SYNC_W   = ADDR_W + 13;

    // ==========================================
    // synchroniser stages for every bus pin
    reg  [SYNC_W-1:0] s1_ff;       // first stage, read only by s2
    reg  [SYNC_W-1:0] s2_ff;       // stable stage
    reg  [SYNC_W-1:0] s3_ff;       // previous stable, for edges
    wire [SYNC_W-1:0] pins;        // raw pin bundle
    wire [ADDR_W-1:0] cur_addr;    // stable address
    wire [ADDR_W-1:0] old_addr;    // address one cycle earlier
    wire [7:0]        old_data;    // write data one cycle earlier
    wire              cur_aen;     // stable aen
    wire              old_aen;     // previous aen
    wire              cur_rd;      // read strobe active
    wire              old_rd;      // read strobe active before
    wire              old_wr;      // write strobe active before
    wire              cur_wr;      // write strobe active
    wire              cur_ack;     // dma acknowledge active
    wire              old_ack;     // dma acknowledge active before
    wire              old_tc;      // terminal count before

    assign pins     = {i_io_dma_bits(i_dma_ack_n, i_dma_tc), i_io_aen, ~i_io_rd_n, ~i_io_wr_n, i_io_data, i_io_addr};
    assign cur_addr = s2_ff[ADDR_W-1:0];
    assign old_addr = s3_ff[ADDR_W-1:0];
    assign old_data = s3_ff[ADDR_W+7:ADDR_W];
    assign cur_wr   = s2_ff[ADDR_W+8];
    assign old_wr   = s3_ff[ADDR_W+8];
    assign cur_rd   = s2_ff[ADDR_W+9];
    assign old_rd   = s3_ff[ADDR_W+9];
    assign cur_aen  = s2_ff[ADDR_W+10];
    assign old_aen  = s3_ff[ADDR_W+10];
    assign cur_ack  = s2_ff[ADDR_W+12];
    assign old_ack  = s3_ff[ADDR_W+12];
    assign old_tc   = s3_ff[ADDR_W+11];

    // pack dma pins: acknowledge made active high
    function [1:0] i_io_dma_bits;
        input ack_n;
        input tc;
        begin
            i_io_dma_bits = {~ack_n, tc};
        end
    endfunction

    // address hit for programmed i/o, blocked while aen or dack
    function hit;
        input [ADDR_W-1:0] a;
        input              aen;
        input              ack;
        input [ADDR_W-1:0] port;
        begin
            hit = (a == port) && !aen && !ack;
        end
    endfunction

    // two-flop synchroniser plus edge stage
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_ff <= {SYNC_W{1'b0}};
            s2_ff <= {SYNC_W{1'b0}};
            s3_ff <= {SYNC_W{1'b0}};
        end else begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // ==========================================
    // bus events, taken at the trailing edge of each strobe
    wire rd_end  = old_rd && !cur_rd;
    wire wr_end  = old_wr && !cur_wr;
    wire rd_data = rd_end && hit(old_addr, old_aen, old_ack, `FDH_DATA_PORT);
    wire wr_data = wr_end && hit(old_addr, old_aen, old_ack, `FDH_DATA_PORT);
    wire wr_sel  = wr_end && hit(old_addr, old_aen, old_ack, `FDH_SEL_PORT);
    wire wr_mask = wr_end && hit(old_addr, old_aen, old_ack, `FDH_MASK_PORT);
    wire dma_rd  = rd_end && old_ack;  // memory takes a byte
    wire dma_wr  = wr_end && old_ack;  // memory gives a byte

    // ==========================================
    // control state
    reg [4:0]  state_ff;              // one-hot state
    reg [4:0]  nxt_state;             // next state
    reg [2:0]  idx_ff;                // stack position
    reg        sel_armed_ff;          // select seen, waiting for first byte
    reg        busy_ff;               // busy indication
    reg [1:0]  mask_ff;               // irq and dma enables
    reg [7:0]  blk_ff [0:5];          // command block stack
    reg [7:0]  sense_ff [0:3];        // sense byte stack
    reg        err_ff;                // last command failed
    reg        drive_ff;              // drive of last command
    reg        dma_dir_rd_ff;         // pending byte goes to memory
    reg [7:0]  dma_buf_ff;            // byte waiting for dma
    reg        ecc_clr;               // clear ecc at command start
    reg        ecc_feed;              // byte enters ecc
    reg [7:0]  ecc_byte;              // byte fed to ecc
    wire       ecc_bad;               // ecc remainder nonzero
    wire [7:0] status_byte;           // completion status
    wire [7:0] cond_byte;             // controller_condition view
    reg  [7:0] data_view;             // visible stack entry
    wire [7:0] blk_op;                // opcode byte of block
    integer    n;                     // reset loop index

    assign blk_op = blk_ff[0];

    // completion status: error in bit 1, drive in bit 5, rest zero
    assign status_byte = {2'b00, drive_ff, 3'b000, err_ff, 1'b0};

    // controller_condition: pure view of state, no storage
    assign cond_byte = {2'b00, o_irq, 1'b0, busy_ff,
                        state_ff[1] | sel_armed_ff,
                        state_ff[3] | state_ff[4],
                        state_ff[1] | state_ff[3] | state_ff[4] | sel_armed_ff};

    // the one stack entry presented on the data register
    always @* begin
        case (state_ff)
            ST_SENSE: data_view = sense_ff[idx_ff[1:0]];
            ST_STAT:  data_view = status_byte;
            ST_CMD:   data_view = blk_ff[idx_ff];
            default:  data_view = 8'h00;
        endcase
    end

    // ==========================================
    // next-state decode
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (wr_sel) begin
                    nxt_state = ST_CMD;
                end
            end
            ST_CMD: begin
                if (wr_data && idx_ff == `FDH_BLK_LAST) begin
                    if (blk_ff[0][4:0] == `FDH_OPC_SENSE) begin
                        nxt_state = ST_SENSE;
                    end else begin
                        nxt_state = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                if (i_exec_done) begin
                    nxt_state = ST_STAT;
                end
            end
            ST_SENSE: begin
                if (rd_data && idx_ff == `FDH_SENSE_LAST) begin
                    nxt_state = ST_STAT;
                end
            end
            ST_STAT: begin
                if (rd_data) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (wr_sel) begin
            nxt_state = ST_CMD;  // select restarts the stack
        end
    end

    // ==========================================
    // main sequencer: stack, busy, status, sense, interrupt
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff     <= ST_IDLE;
            idx_ff       <= 3'h0;
            sel_armed_ff <= 1'b0;
            busy_ff      <= 1'b0;
            mask_ff      <= `FDH_MASK_RESET;
            err_ff       <= 1'b0;
            drive_ff     <= 1'b0;
            o_irq        <= 1'b0;
            o_sel_pulse  <= 1'b0;
            o_cmd_start  <= 1'b0;
            for (n = 0; n < 6; n = n + 1) begin
                blk_ff[n] <= 8'h00;
            end
            for (n = 0; n < 4; n = n + 1) begin
                sense_ff[n] <= 8'h00;
            end
        end else begin
            state_ff    <= nxt_state;
            o_sel_pulse <= wr_sel;
            o_cmd_start <= 1'b0;
            if (wr_mask) begin
                mask_ff <= old_data[1:0];
            end
            if (wr_sel) begin
                idx_ff       <= 3'h0;
                sel_armed_ff <= 1'b1;
                busy_ff      <= 1'b0;
                o_irq        <= 1'b0;
            end else begin
                case (state_ff)
                    ST_CMD: begin
                        if (wr_data) begin
                            blk_ff[idx_ff] <= old_data;
                            sel_armed_ff   <= 1'b0;
                            busy_ff        <= 1'b1;
                            if (idx_ff == `FDH_BLK_LAST) begin
                                idx_ff      <= 3'h0;
                                o_cmd_start <= (blk_ff[0][4:0] != `FDH_OPC_SENSE);
                            end else begin
                                idx_ff <= idx_ff + 3'h1;
                            end
                        end
                    end
                    ST_EXEC: begin
                        if (i_exec_done) begin
                            drive_ff <= blk_ff[1][5];
                            if (i_exec_err_type != 2'b00 || i_exec_err_code != 4'h0) begin
                                err_ff      <= 1'b1;
                                sense_ff[0] <= {i_exec_addr_valid, 1'b0,
                                                i_exec_err_type, i_exec_err_code};
                            end else if (i_exec_chk_ecc && ecc_bad) begin
                                err_ff      <= 1'b1;
                                sense_ff[0] <= {i_exec_addr_valid, 1'b0, `FDH_ERR_DATA};
                            end else begin
                                err_ff      <= 1'b0;
                                sense_ff[0] <= {i_exec_addr_valid, 7'h00};
                            end
                            sense_ff[1] <= {2'b00, blk_ff[1][5:0]};
                            sense_ff[2] <= blk_ff[2];
                            sense_ff[3] <= blk_ff[3];
                            o_irq       <= mask_ff[`FDH_MASK_IRQ_EN];
                        end
                    end
                    ST_SENSE: begin
                        if (idx_ff == 3'h0 && !busy_ff) begin
                            busy_ff <= 1'b1;
                        end
                        if (rd_data) begin
                            if (idx_ff == `FDH_SENSE_LAST) begin
                                idx_ff <= 3'h0;
                                err_ff <= 1'b0;
                                o_irq  <= mask_ff[`FDH_MASK_IRQ_EN];
                            end else begin
                                idx_ff <= idx_ff + 3'h1;
                            end
                        end
                    end
                    ST_STAT: begin
                        if (rd_data) begin
                            busy_ff <= 1'b0;
                            o_irq   <= 1'b0;
                        end
                    end
                    default: begin
                        idx_ff <= 3'h0;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // command fields for the execution engine
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cmd_class_op <= 8'h00;
            o_cmd_drive    <= 1'b0;
            o_cmd_head     <= 5'h00;
            o_cmd_cyl      <= 10'h000;
            o_cmd_sector   <= 6'h00;
            o_cmd_count    <= 8'h00;
            o_cmd_control  <= 8'h00;
        end else if (state_ff == ST_CMD && wr_data && idx_ff == `FDH_BLK_LAST) begin
            o_cmd_class_op <= blk_op;
            o_cmd_drive    <= blk_ff[1][5];
            o_cmd_head     <= blk_ff[1][4:0];
            o_cmd_cyl      <= {blk_ff[2][7:6], blk_ff[3]};
            o_cmd_sector   <= blk_ff[2][5:0];
            o_cmd_count    <= blk_ff[4];
            o_cmd_control  <= old_data;
        end
    end

    // ==========================================
    // dma byte mover: one byte buffered each way
    assign o_rd_ready = state_ff[2] && !o_dma_req && mask_ff[`FDH_MASK_DMA_EN];

    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_dma_req     <= 1'b0;
            dma_dir_rd_ff <= 1'b0;
            dma_buf_ff    <= 8'h00;
            o_wr_valid    <= 1'b0;
            o_wr_byte     <= 8'h00;
            o_dma_tc_seen <= 1'b0;
        end else begin
            o_wr_valid    <= 1'b0;
            o_dma_tc_seen <= 1'b0;
            if (!state_ff[2] || wr_sel) begin
                o_dma_req <= 1'b0;
            end else if (o_dma_req) begin
                if (cur_ack) begin
                    o_dma_req <= 1'b0;  // acknowledge degates the request
                end
            end else if (i_rd_valid && o_rd_ready) begin
                dma_buf_ff    <= i_rd_byte;
                dma_dir_rd_ff <= 1'b1;
                o_dma_req     <= 1'b1;
            end else if (i_wr_want && mask_ff[`FDH_MASK_DMA_EN]) begin
                dma_dir_rd_ff <= 1'b0;
                o_dma_req     <= 1'b1;
            end
            if (dma_wr && !dma_dir_rd_ff) begin
                o_wr_byte  <= old_data;
                o_wr_valid <= 1'b1;
            end
            if ((dma_wr || dma_rd) && old_tc) begin
                o_dma_tc_seen <= 1'b1;
            end
        end
    end

    // ecc stream: every record byte, either direction, except a memory byte in the cycle a disk byte is taken and any byte in the o_cmd_start cycle
    always @* begin
        ecc_clr  = o_cmd_start;
        ecc_feed = 1'b0;
        ecc_byte = 8'h00;
        if (i_rd_valid && o_rd_ready) begin
            ecc_feed = 1'b1;
            ecc_byte = i_rd_byte;
        end else if (dma_wr && !dma_dir_rd_ff && state_ff[2]) begin
            ecc_feed = 1'b1;
            ecc_byte = old_data;
        end
    end

    fdh_ecc32 #(
        .POLY (`FDH_ECC_POLY)
    ) fdh_ecc32_inst (
        .i_sys_clk    (i_sys_clk),
        .i_sys_rst    (i_sys_rst),
        .i_clear      (ecc_clr),
        .i_byte_valid (ecc_feed),
        .i_byte       (ecc_byte),
        .o_syndrome   (o_ecc_syndrome),
        .o_nonzero    (ecc_bad)
    );

    // ==========================================
    // read data drive: registered, enable low while driving
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_io_data      <= 8'h00;
            o_io_data_oe_n <= 1'b1;
        end else if (cur_rd && cur_ack && state_ff[2] && dma_dir_rd_ff) begin
            o_io_data      <= dma_buf_ff;
            o_io_data_oe_n <= 1'b0;
        end else if (cur_rd && hit(cur_addr, cur_aen, cur_ack, `FDH_DATA_PORT)) begin
            o_io_data      <= data_view;
            o_io_data_oe_n <= 1'b0;
        end else if (cur_rd && hit(cur_addr, cur_aen, cur_ack, `FDH_COND_PORT)) begin
            o_io_data      <= cond_byte;
            o_io_data_oe_n <= 1'b0;
        end else if (cur_rd && hit(cur_addr, cur_aen, cur_ack, `FDH_MASK_PORT)) begin
            o_io_data      <= {6'h00, mask_ff};
            o_io_data_oe_n <= 1'b0;
        end else begin
            o_io_data      <= 8'h00;
            o_io_data_oe_n <= 1'b1;
        end
    end

endmodule

// ==== testbench/fdh_host_port_properties.sv ====
// assertion checker of the host port pin timing
module fdh_chk (
    // clock, reset, bus strobes and engine done
    input logic i_sys_clk, i_sys_rst, i_io_rd_n, i_io_wr_n, i_dma_ack_n, i_exec_done,
    // registered outputs
    input logic o_io_data_oe_n, o_irq, o_sel_pulse, o_cmd_start, o_dma_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    AST_SEL: assert property (o_sel_pulse |-> $past(!i_io_wr_n, 7)) else $error("stray select");
    AST_GO: assert property (o_cmd_start |-> $past(!i_io_wr_n, 7)) else $error("stray start");
    AST_GO_ONCE: assert property (o_cmd_start |=> !o_cmd_start) else $error("long start");
    AST_OE: assert property (!o_io_data_oe_n |-> $past(!i_io_rd_n, 3)) else $error("stray drive");
    AST_OE_OFF: assert property (i_io_rd_n [*5] |-> o_io_data_oe_n) else $error("bus held");
    AST_IRQ_UP: assert property ($rose(o_irq) |-> $past(i_exec_done, 1) || $past(i_exec_done, 2)
        || $past(!i_io_rd_n, 8)) else $error("stray irq");
    AST_IRQ_DN: assert property ($fell(o_irq) |-> $past(!i_io_rd_n, 7)) else $error("irq lost");
    AST_DRQ: assert property ($fell(o_dma_req) |-> $past(!i_dma_ack_n, 3)) else $error("dreq lost");
    cover property (o_cmd_start);
    cover property ($fell(o_irq));
    cover property ($fell(o_dma_req));
endmodule
bind fdh_host_port fdh_chk fdh_chk_inst (.*);

// ==== testbench/fdh_host.sv ====
// host processor and dma model on the i/o bus pins
module fdh_host (
    // clock and read data from the port
    input  logic       i_sys_clk,
    input  logic [7:0] o_io_data,
    // bus pins driven into the port
    output logic [9:0] i_io_addr,
    output logic [7:0] i_io_data,
    output logic       i_io_aen, i_io_rd_n, i_io_wr_n, i_dma_ack_n, i_dma_tc
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {i_io_addr, i_io_data, i_io_aen, i_io_rd_n, i_io_wr_n, i_dma_ack_n, i_dma_tc} = 23'h00000e;
    // strobe low five clocks, data kept four clocks past the strobe, then scrambled
    // a dma cycle moves a single byte, so terminal count rides along with every acknowledge
    task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic w, dk, output logic [7:0] r);
        @(negedge i_sys_clk);
        {i_io_addr, i_io_data, i_io_aen, i_dma_ack_n, i_dma_tc} = {a, d, dk, !dk, dk};
        {i_io_wr_n, i_io_rd_n} = {!w, w};
        repeat (5) @(negedge i_sys_clk);
        r = o_io_data;
        {i_io_rd_n, i_io_wr_n, i_dma_ack_n, i_io_aen, i_dma_tc} = 5'h1c;
        repeat (4) @(negedge i_sys_clk);
        i_io_data = ~d;
        @(negedge i_sys_clk);
    endtask
endmodule

// ==== testbench/fdh_host_port_tb.sv ====
// self-checking bench of the fixed disk host port
`include "fdh_defs.vh"
module fdh_host_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_sys_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [9:0]  i_io_addr, o_cmd_cyl;
    logic [7:0]  i_io_data, o_io_data, o_cmd_class_op, o_cmd_count, o_cmd_control, o_wr_byte, q, wb;
    logic [7:0]  i_rd_byte = 8'h5a;
    logic [4:0]  o_cmd_head;
    logic [5:0]  o_cmd_sector;
    logic [31:0] o_ecc_syndrome;
    logic [1:0]  i_exec_err_type = 2'h0;
    logic [3:0]  i_exec_err_code = 4'h0;
    logic        i_io_aen, i_io_rd_n, i_io_wr_n, i_dma_ack_n, i_dma_tc, o_io_data_oe_n, o_dma_req, o_irq;
    logic        o_sel_pulse, o_cmd_start, o_cmd_drive, o_rd_ready, o_wr_valid, o_dma_tc_seen;
    logic        i_rd_valid = 1'b0, i_wr_want = 1'b0, i_exec_done = 1'b0;
    logic        i_exec_addr_valid = 1'b1, i_exec_chk_ecc = 1'b1;
    int          err_total = 0, checks_done = 0, nsel = 0, nst = 0, es = 0, est = 0, cyc_n = 0, ntc = 0;
    logic [7:0]  bb [5] = '{8'h13, 8'h8a, 8'h34, 8'h02, 8'h05};
    logic [7:0]  sb [4] = '{8'h94, 8'h13, 8'h8a, 8'h34};
    fdh_host_port fdh_host_port_inst (.*);
    fdh_host fdh_host_inst (.*);
    always #5 i_sys_clk = ~i_sys_clk;
    // pulse counts and cycle ceiling, sampled away from the launching edge
    always @(negedge i_sys_clk) begin
        nsel += o_sel_pulse;
        nst += o_cmd_start;
        ntc += o_dma_tc_seen;
        if (o_wr_valid) wb = o_wr_byte;
        cyc_n++;
        if (cyc_n == 5000) begin
            err_total++;
            finish_test;
        end
    end
    task automatic chk(input string n, input logic [63:0] s, e);
        checks_done++;
        err_total += (s !== e);
        if (s !== e) $display("[FAIL] %s expected %h seen %h", n, e, s);
    endtask
    // reference remainder of one byte from a zero seed, msb first
    function automatic logic [31:0] ecc_ref(input logic [7:0] d);
        ecc_ref = `FDH_ECC_SEED;
        for (int k = 7; k >= 0; k--)
            ecc_ref = {ecc_ref[30:0], 1'b0} ^ (ecc_ref[31] ^ d[k] ? `FDH_ECC_POLY : 32'h0);
    endfunction
    task automatic finish_test;
        if (err_total == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        fdh_host_inst.cyc(a, d, 1'b1, 1'b0, q);
    endtask
    task automatic rd(input logic [9:0] a);
        fdh_host_inst.cyc(a, 8'h00, 1'b0, 1'b0, q);
    endtask
    // select, then the six-byte command block
    task automatic blk(input logic [7:0] op, input logic drv);
        wr(10'h322, 8'h00);
        es++;
        wr(10'h320, op);
        rd(10'h321);
        chk("busy", q[3], 1'b1);
        for (int i = 0; i < 5; i++) wr(10'h320, bb[i] | (i == 0 ? {2'h0, drv, 5'h00} : 8'h00));
        chk("selects", nsel, es);
    endtask
    // one command: optional dma byte each way, completion, and sense on error
    task automatic run(input logic [7:0] mask, input logic drv, err);
        wr(10'h323, mask);
        blk(8'h01, drv);
        est++;
        chk("start", nst, est);
        chk("fields", {o_cmd_class_op, o_cmd_drive, o_cmd_head, o_cmd_cyl, o_cmd_sector, o_cmd_count,
            o_cmd_control}, {8'h01, drv, 5'h13, 10'h234, 6'h0a, 16'h0205});
        i_rd_valid = 1'b1;
        chk("rd ready", o_rd_ready, mask[1]);
        @(negedge i_sys_clk);
        i_rd_valid = 1'b0;
        chk("dma req", o_dma_req, mask[1]);
        if (mask[1]) begin
            fdh_host_inst.cyc(10'h000, 8'h00, 1'b0, 1'b1, q);
            chk("dma byte", q, 8'h5a);
            chk("ecc", o_ecc_syndrome, ecc_ref(8'h5a));
            i_wr_want = 1'b1;
            @(negedge i_sys_clk);
            i_wr_want = 1'b0;
            fdh_host_inst.cyc(10'h000, 8'hc3, 1'b1, 1'b1, q);
            chk("dma write", {ntc, wb}, {32'd2, 8'hc3});
        end
        {i_exec_err_type, i_exec_err_code, i_exec_done} = {1'b0, err, 1'b0, err, 2'h0, 1'b1};
        @(negedge i_sys_clk);
        i_exec_done = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        chk("irq", o_irq, mask[0]);
        rd(10'h320);
        chk("status", q, {2'h0, drv, 3'h0, err, 1'b0});
        rd(10'h321);
        chk("end", {q[3], o_irq}, 2'h0);
        if (err) begin
            blk(8'h03, drv);
            for (int i = 0; i < 4; i++) begin
                rd(10'h320);
                chk("sense", q, sb[i] | (i == 1 ? {2'h0, drv, 5'h00} : 8'h00));
            end
            rd(10'h320);
            chk("sense end", q, {2'h0, drv, 5'h00});
        end
    endtask
    initial begin
        repeat (10) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        chk("reset", {o_io_data, o_io_data_oe_n, o_dma_req, o_irq}, 11'h004);
        repeat (3) @(negedge i_sys_clk);
        wr(10'h321, 8'hff);
        rd(10'h321);
        chk("condition", q, 8'h00);
        run(8'h03, 1'b0, 1'b1);
        run(8'h00, 1'b1, 1'b0);
        finish_test;
    end
endmodule
